// ### tb/sample_clock_checker.sv
// Purpose: port-level assertions for the sample clock block
// Assumes: bound to the top module, ctrl reset value zero
// Notes: mode is tracked from acknowledged writes
`timescale 1ns/1ps
`include "sample_clock_defines.svh"
module sample_clock_checker #(
   parameter int LATENCY = 2
) (
   // clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // bus
   input wire sample_clock_pkg::wb_req_t wbReq,
   input wire sample_clock_pkg::wb_rsp_t wbRsp,
   // samples and markers
   input wire logic [11:0]               sampleRise,
   input wire logic                      sampleValid,
   input wire logic                      markerTriggerInput,
   input wire logic                      sysrefIn,
   // lanes and delay
   input wire logic [11:0]               laneDataRise,
   input wire logic [11:0]               laneDataFall,
   input wire logic                      laneDataValid,
   input wire logic                      laneOutputStrobe,
   input wire logic                      laneOutputClock,
   input wire sample_clock_pkg::aperture_t apertureDelay
);
   import sample_clock_pkg::*;
   localparam int LAT = LATENCY + 1;
   logic [2:0] ctrl_q;
   logic [3:0] quiet_q;
   logic       steady;
   logic       srefPrev_q;
   logic       srefPrev2_q;
   assign steady = quiet_q > LAT;
   // sysref history, a captured edge restarts the lane clock
   always_ff @(posedge clk) begin
      if (rst) begin
         srefPrev_q  <= 1'b0;
         srefPrev2_q <= 1'b0;
      end else begin
         srefPrev_q  <= sysrefIn;
         srefPrev2_q <= srefPrev_q;
      end
   end
   // mode seen by software writes
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q  <= 3'h0;
         quiet_q <= 4'h0;
      end else if (wbRsp.ack && wbReq.we && wbReq.adr == `ADDR_CLOCK_CONTROL_ONE && wbReq.sel[0]) begin
         ctrl_q  <= wbReq.dat[2:0];
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_ack; wbReq.cyc && wbReq.stb && !wbRsp.ack && !wbRsp.err |=> (wbRsp.ack || wbRsp.err) ##1 !(wbRsp.ack || wbRsp.err); endproperty
   a_ack: assert property (p_ack) else $error("bus answer late or long");
   property p_valid; sampleValid |-> ##LAT laneDataValid; endproperty
   a_valid: assert property (p_valid) else $error("lane valid latency wrong");
   property p_plain; laneDataValid && steady && !ctrl_q[0] |-> laneDataRise[0] == $past(sampleRise[0], LAT); endproperty
   a_plain: assert property (p_plain) else $error("lsb altered while marking off");
   property p_mark; laneDataValid && steady && ctrl_q[1:0] == 2'b01 |-> laneDataRise[0] == $past(markerTriggerInput, LAT); endproperty
   a_mark: assert property (p_mark) else $error("marker bit wrong");
   property p_sref; laneDataValid && steady && ctrl_q[1:0] == 2'b11 |-> laneDataRise[0] == $past(sysrefIn, LAT); endproperty
   a_sref: assert property (p_sref) else $error("sysref marker bit wrong");
   property p_dual; laneDataValid && steady && !ctrl_q[2] |-> laneDataFall == 12'h000; endproperty
   a_dual: assert property (p_dual) else $error("falling word in dual mode");
   property p_strobe; $rose(sysrefIn) |=> laneOutputStrobe; endproperty
   a_strobe: assert property (p_strobe) else $error("no strobe after sysref");
   property p_lclk; !$past(rst) && !(sysrefIn && !srefPrev_q) && !(srefPrev_q && !srefPrev2_q)
      |=> laneOutputClock != $past(laneOutputClock); endproperty
   a_lclk: assert property (p_lclk) else $error("lane clock not toggling");
   property p_delay; $changed(apertureDelay.fine) || $changed(apertureDelay.halfInvert)
      |-> $past(wbRsp.ack && wbReq.we); endproperty
   a_delay: assert property (p_delay) else $error("delay moved without write");
endmodule : sample_clock_checker

// ### tb/sysref_source.sv
// Purpose: sysref source and strobe counting receiver
// Assumes: one clock, changes just after rising edge
// Notes: period zero means pulse only
`timescale 1ns/1ps
module sysref_source (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bench control
   input  wire logic        fire,
   input  wire logic [15:0] period,
   // device side
   output logic             sysrefOut,
   input  wire logic        strobe,
   output logic [15:0]      strobeCount
);
   logic [15:0] cnt_q;
   // single pulse or periodic train
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q     <= 16'h0000;
         sysrefOut <= 1'b0;
      end else begin
         cnt_q     <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
         sysrefOut <= fire || (period != 16'h0000 && cnt_q == 16'h0000);
      end
   end
   // receiver counts strobes, no fixed phase assumed
   always_ff @(posedge clk) begin
      if (rst) begin
         strobeCount <= 16'h0000;
      end else if (strobe) begin
         strobeCount <= strobeCount + 16'h0001;
      end
   end
endmodule : sysref_source

// ### tb/tb_top.sv
// Purpose: self-checking bench for the sample clock block
// Assumes: latency 2, ramp period 256
// Notes: expected words come from bench functions
`timescale 1ns/1ps
`include "sample_clock_defines.svh"
module tb_top;
   import sample_clock_pkg::*;
   localparam int LAT = 3;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   wb_req_t     wbReq;
   wb_rsp_t     wbRsp;
   aperture_t   apertureDelay;
   logic [11:0] sampleRise, sampleFall, laneDataRise, laneDataFall;
   logic        sampleValid, markerTriggerInput, sysrefIn, laneDataValid, laneOutputStrobe, laneOutputClock;
   logic        fire, e;
   logic [15:0] period, strobeCount, c0, lfsr_q;
   logic [31:0] rd, v;
   logic [11:0] expR [0:63];
   logic [11:0] expF [0:63];
   int          err_count = 0;
   int          checks = 0;
   always #10 clk = ~clk;
   sample_clock_timestamp_sync #(.LATENCY(2)) u_sample_clock_timestamp_sync (.clk(clk), .rst(rst),
      .wbReq(wbReq), .wbRsp(wbRsp), .sampleRise(sampleRise), .sampleFall(sampleFall), .sampleValid(sampleValid),
      .markerTriggerInput(markerTriggerInput), .sysrefIn(sysrefIn), .laneDataRise(laneDataRise),
      .laneDataFall(laneDataFall), .laneDataValid(laneDataValid), .laneOutputStrobe(laneOutputStrobe),
      .laneOutputClock(laneOutputClock), .apertureDelay(apertureDelay));
   sysref_source u_sysref_source (.clk(clk), .rst(rst), .fire(fire), .period(period), .sysrefOut(sysrefIn),
      .strobe(laneOutputStrobe), .strobeCount(strobeCount));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [11:0] exp_word(input logic [11:0] s, input logic [2:0] c, input logic m, input logic y);
      return c[0] ? {s[11:1], c[1] ? y : m} : s;
   endfunction : exp_word
   task automatic test_done;
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
      do begin
         @(posedge clk);
         n++;
      end while (!wbRsp.ack && !wbRsp.err);
      rd = wbRsp.dat;
      e = wbRsp.err;
      check(n, 32'h0000_0002);
      wbReq <= '0;
      @(posedge clk);
   endtask : wb
   initial begin
      wbReq = '0;
      sampleRise = 12'h000;
      sampleFall = 12'h000;
      sampleValid = 1'b0;
      markerTriggerInput = 1'b0;
      fire = 1'b0;
      period = 16'h0000;
      lfsr_q = 16'h0057;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, `ADDR_APERTURE_DELAY, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(1'b0, `ADDR_FRAME_SETUP, 32'h0000_0000);
      check(rd[15:0], {`RST_FRAME, 4'h0, `RST_DEMUX});
      wb(1'b1, 8'h40, 32'h0000_0001);
      check(e, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr(lfsr(lfsr_q));
         v = (i == 0) ? 32'h00FF_FF01 : {8'h00, lfsr_q, 7'h00, lfsr_q[3]};
         wb(1'b1, `ADDR_APERTURE_DELAY, v);
         @(posedge clk);
         check(apertureDelay, {v[0], v[15:8], v[23:16]});
         wb(1'b0, `ADDR_APERTURE_DELAY, 32'h0000_0000);
         check(rd[23:0], v[23:0]);
      end
      wb(1'b1, `ADDR_APERTURE_DELAY, 32'h0000_0000);
      for (int r = 0; r < 2; r++) begin
         wb(1'b1, `ADDR_DELAY_RAMP, {30'h0, r[0], 1'b1});
         wb(1'b1, `ADDR_APERTURE_DELAY, {16'h0000, r ? 8'h0C : 8'h03, 8'h00});
         @(posedge clk);
         for (int k = 1; k < 4; k++) begin
            repeat (256) @(posedge clk);
            check(apertureDelay.coarse, r ? ((k == 3) ? 12 : 3 + 4 * k) : k);
         end
         wb(1'b0, `ADDR_STATUS, 32'h0000_0000);
         check(rd[8:0], {1'b0, r ? 8'h0C : 8'h03});
      end
      wb(1'b1, `ADDR_DELAY_RAMP, 32'h0000_0000);
      wb(1'b1, `ADDR_FRAME_SETUP, 32'h0000_0401);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
      wb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      check(rd[9], 1'b1);
      wb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      check(rd[9], 1'b0);
      c0 = strobeCount;
      repeat (64) @(posedge clk);
      check(strobeCount - c0, 16'h0008);
      period <= 16'h0010;
      sampleValid <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, `ADDR_CLOCK_CONTROL_ONE, c);
         repeat (LAT + 2) @(posedge clk);
         for (int i = 0; i < 40; i++) begin
            lfsr_q = lfsr(lfsr_q);
            sampleRise <= lfsr_q[11:0];
            sampleFall <= lfsr_q[15:4];
            markerTriggerInput <= lfsr_q[7];
            #1;
            expR[i] = exp_word(sampleRise, c[2:0], markerTriggerInput, sysrefIn);
            expF[i] = c[2] ? exp_word(sampleFall, c[2:0], markerTriggerInput, sysrefIn) : 12'h000;
            if (i >= LAT) check({laneDataValid, laneDataRise, laneDataFall}, {1'b1, expR[i - LAT], expF[i - LAT]});
            @(posedge clk);
         end
      end
      period <= 16'h0000;
      test_done();
   end
   initial begin
      #(20 * 10000);
      err_count++;
      test_done();
   end
endmodule : tb_top
bind sample_clock_timestamp_sync sample_clock_checker #(.LATENCY(LATENCY)) u_sample_clock_checker (.clk(clk),
   .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .sampleRise(sampleRise), .sampleValid(sampleValid),
   .markerTriggerInput(markerTriggerInput), .sysrefIn(sysrefIn), .laneDataRise(laneDataRise),
   .laneDataFall(laneDataFall), .laneDataValid(laneDataValid), .laneOutputStrobe(laneOutputStrobe),
   .laneOutputClock(laneOutputClock), .apertureDelay(apertureDelay));

// ### verilog/delay_ramp.sv
// Purpose: walks the applied coarse delay toward its target
// Assumes: target written by software, step every period
// Notes: target change restarts the period count
`timescale 1ns/1ps
`include "sample_clock_defines.svh"
module delay_ramp #(
   parameter int PERIOD = `RAMP_PERIOD_CYCLES
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       enable,
   input  wire logic       fast,
   input  wire logic       restart,
   input  wire logic [7:0] target,
   // result
   output logic [7:0]      applied,
   output logic            busy
);
   import sample_clock_pkg::*;

   ramp_state_t state_q;
   logic [8:0]  cnt_q;
   logic [7:0]  step;
   logic [7:0]  diff;

   always_comb begin
      step = fast ? `RAMP_STEP_FAST : `RAMP_STEP_SLOW;
      diff = (target > applied) ? (target - applied) : (applied - target);
   end

   // ramp sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= RAMP_IDLE;
         cnt_q   <= 9'h000;
         applied <= `RST_COARSE;
      end else if (!enable) begin
         state_q <= RAMP_IDLE;
         cnt_q   <= 9'h000;
         applied <= target;
      end else begin
         unique case (state_q)
            RAMP_IDLE: begin
               cnt_q <= 9'h000;
               if (restart || target != applied) begin
                  state_q <= RAMP_WAIT;
               end
            end
            RAMP_WAIT: begin
               if (restart) begin
                  cnt_q <= 9'h000;
               // the step state spends the last cycle of each period
               end else if (cnt_q == 9'(PERIOD - 2)) begin
                  cnt_q   <= 9'h000;
                  state_q <= RAMP_STEP;
               end else begin
                  cnt_q <= cnt_q + 9'h001;
               end
            end
            RAMP_STEP: begin
               // one or four lsbs per period
               if (diff <= step) begin
                  applied <= target;
                  state_q <= RAMP_IDLE;
               end else begin
                  applied <= (target > applied) ? applied + step : applied - step;
                  state_q <= RAMP_WAIT;
               end
            end
            default: state_q <= RAMP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= enable && (target != applied);
      end
   end

endmodule : delay_ramp

// ### verilog/sample_clock_defines.svh
// Purpose: constants for the sample clock, marker and aperture delay block
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes: register offsets are byte addresses, one word each
// Contract
// - no marker data unless insert enable set
// - marker replaces sample lsb when enabled
// - upper eleven bits plus marker, equal latency
// - asynchronous trigger sampled with the analog input
// - select bit takes marker from sysref
// - dual channel samples rising edge only
// - single channel samples both clock edges
// - device clock also clocks processing and outputs
// - captured sysref resets dividers and strobe
// - sysref captured on a defined clock edge
// - invert bit adds half period delay
// - coarse and fine give 256 settings
// - invert, coarse, fine act independently
// - delay shifts all internal clocks
// - delay changes allowed while converting
// - ramp one or four coarse steps per 256
`ifndef SAMPLE_CLOCK_DEFINES_SVH
`define SAMPLE_CLOCK_DEFINES_SVH

`define ADDR_CLOCK_CONTROL_ONE  8'h00
`define ADDR_APERTURE_DELAY     8'h04
`define ADDR_DELAY_RAMP         8'h08
`define ADDR_FRAME_SETUP        8'h0C
`define ADDR_STATUS             8'h10

`define BIT_MARKER_INSERT_EN    0
`define BIT_SYSREF_MARKER_SEL   1
`define BIT_SINGLE_CHANNEL      2
`define BIT_HALF_PERIOD_INV     0
`define LSB_COARSE              8
`define LSB_FINE                16
`define BIT_RAMP_ENABLE         0
`define BIT_RAMP_SPEED          1

`define RST_COARSE              8'h00
`define RST_FINE                8'h00
`define RST_DEMUX               4'h0
`define RST_FRAME               8'h08

`define RAMP_PERIOD_CYCLES      256
`define RAMP_STEP_SLOW          8'h01
`define RAMP_STEP_FAST          8'h04

`endif

// ### verilog/sample_clock_pkg.sv
// Purpose: types for the sample clock, marker and aperture delay block
// Assumes: nothing beyond the defines header
// Notes: structs group wishbone request and answer, and the aperture delay codes
package sample_clock_pkg;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      logic       halfInvert;
      logic [7:0] coarse;
      logic [7:0] fine;
   } aperture_t;

   typedef enum logic [2:0] {
      RAMP_IDLE  = 3'b001,
      RAMP_WAIT  = 3'b010,
      RAMP_STEP  = 3'b100
   } ramp_state_t;

endpackage : sample_clock_pkg

// ### verilog/sample_clock_timestamp_sync.sv
// Purpose: sample marker insertion, sysref divider reset and aperture delay control
// Assumes: clk is the device clock; sample inputs already synchronous to it
// Notes: analog delays are exported as control codes only
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sample_clock_defines.svh"
module sample_clock_timestamp_sync #(
   parameter int LATENCY = 2
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // wishbone slave
   input  wire sample_clock_pkg::wb_req_t wbReq,
   output sample_clock_pkg::wb_rsp_t      wbRsp,
   // converter samples, rising and falling half
   input  wire logic [11:0]               sampleRise,
   input  wire logic [11:0]               sampleFall,
   input  wire logic                      sampleValid,
   // marker sources
   input  wire logic                      markerTriggerInput,
   input  wire logic                      sysrefIn,
   // output lanes
   output logic [11:0]                    laneDataRise,
   output logic [11:0]                    laneDataFall,
   output logic                           laneDataValid,
   output logic                           laneOutputStrobe,
   output logic                           laneOutputClock,
   // aperture delay codes
   output sample_clock_pkg::aperture_t    apertureDelay
);
   import sample_clock_pkg::*;

   // register state
   logic       markerInsertEnable_q;
   logic       sysrefMarkerSelect_q;
   logic       singleChannel_q;
   logic       halfInvert_q;
   logic [7:0] coarseTarget_q;
   logic [7:0] fine_q;
   logic       rampEnable_q;
   logic       rampSpeed_q;
   logic [3:0] outputDemux_q;
   logic [7:0] frameLength_q;
   logic       sysrefSeen_q;
   logic       coarseWrite_q;

   // datapath state
   logic       sysrefPrev_q;
   logic [7:0] frameCnt_q;
   logic [3:0] demuxCnt_q;
   logic       laneClk_q;
   logic [LATENCY-1:0][24:0] pipe_q;

   logic [7:0] coarseApplied;
   logic       rampBusy;
   logic       sysrefEdge;
   logic       markerSrc;
   logic       busHit;
   logic       ackNext;
   logic [31:0] rdData;
   logic       mapped;

   assign busHit     = wbReq.cyc && wbReq.stb && !wbRsp.ack && !wbRsp.err;
   assign sysrefEdge = sysrefIn && !sysrefPrev_q;

   // read mux and decode
   always_comb begin
      rdData = 32'h0000_0000;
      mapped = 1'b1;
      unique case (wbReq.adr)
         `ADDR_CLOCK_CONTROL_ONE: begin
            rdData[`BIT_MARKER_INSERT_EN]  = markerInsertEnable_q;
            rdData[`BIT_SYSREF_MARKER_SEL] = sysrefMarkerSelect_q;
            rdData[`BIT_SINGLE_CHANNEL]    = singleChannel_q;
         end
         `ADDR_APERTURE_DELAY: begin
            rdData[`BIT_HALF_PERIOD_INV]       = halfInvert_q;
            rdData[`LSB_COARSE +: 8]           = coarseTarget_q;
            rdData[`LSB_FINE +: 8]             = fine_q;
         end
         `ADDR_DELAY_RAMP: begin
            rdData[`BIT_RAMP_ENABLE] = rampEnable_q;
            rdData[`BIT_RAMP_SPEED]  = rampSpeed_q;
         end
         `ADDR_FRAME_SETUP: begin
            rdData[3:0]  = outputDemux_q;
            rdData[15:8] = frameLength_q;
         end
         `ADDR_STATUS: begin
            rdData[7:0] = coarseApplied;
            rdData[8]   = rampBusy;
            rdData[9]   = sysrefSeen_q;
         end
         default: mapped = 1'b0;
      endcase
      ackNext = busHit && mapped;
   end

   // bus answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (rst) begin
         wbRsp <= '0;
      end else begin
         wbRsp.ack <= ackNext;
         wbRsp.err <= busHit && !mapped;
         wbRsp.dat <= ackNext && !wbReq.we ? rdData : 32'h0000_0000;
      end
   end

   // control register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         markerInsertEnable_q <= 1'b0;
         sysrefMarkerSelect_q <= 1'b0;
         singleChannel_q      <= 1'b0;
         halfInvert_q         <= 1'b0;
         coarseTarget_q       <= `RST_COARSE;
         fine_q               <= `RST_FINE;
         rampEnable_q         <= 1'b0;
         rampSpeed_q          <= 1'b0;
         outputDemux_q        <= `RST_DEMUX;
         frameLength_q        <= `RST_FRAME;
         coarseWrite_q        <= 1'b0;
      end else begin
         coarseWrite_q <= 1'b0;
         if (ackNext && wbReq.we) begin
            unique case (wbReq.adr)
               `ADDR_CLOCK_CONTROL_ONE: begin
                  if (wbReq.sel[0]) begin
                     markerInsertEnable_q <= wbReq.dat[`BIT_MARKER_INSERT_EN];
                     sysrefMarkerSelect_q <= wbReq.dat[`BIT_SYSREF_MARKER_SEL];
                     singleChannel_q      <= wbReq.dat[`BIT_SINGLE_CHANNEL];
                  end
               end
               `ADDR_APERTURE_DELAY: begin
                  // three independent delay fields, changeable live
                  if (wbReq.sel[0]) begin
                     halfInvert_q <= wbReq.dat[`BIT_HALF_PERIOD_INV];
                  end
                  if (wbReq.sel[1]) begin
                     coarseTarget_q <= wbReq.dat[`LSB_COARSE +: 8];
                     coarseWrite_q  <= 1'b1;
                  end
                  if (wbReq.sel[2]) begin
                     fine_q <= wbReq.dat[`LSB_FINE +: 8];
                  end
               end
               `ADDR_DELAY_RAMP: begin
                  if (wbReq.sel[0]) begin
                     rampEnable_q <= wbReq.dat[`BIT_RAMP_ENABLE];
                     rampSpeed_q  <= wbReq.dat[`BIT_RAMP_SPEED];
                  end
               end
               `ADDR_FRAME_SETUP: begin
                  if (wbReq.sel[0]) begin
                     outputDemux_q <= wbReq.dat[3:0];
                  end
                  if (wbReq.sel[1]) begin
                     frameLength_q <= wbReq.dat[15:8];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // coarse delay ramp
   delay_ramp #(
      .PERIOD (`RAMP_PERIOD_CYCLES)
   ) u_ramp (
      .clk     (clk),
      .rst     (rst),
      .enable  (rampEnable_q),
      .fast    (rampSpeed_q),
      .restart (coarseWrite_q),
      .target  (coarseTarget_q),
      .applied (coarseApplied),
      .busy    (rampBusy)
   );

   // delay codes to the analog clock path
   always_ff @(posedge clk) begin
      if (rst) begin
         apertureDelay <= '0;
      end else begin
         apertureDelay.halfInvert <= halfInvert_q;
         apertureDelay.coarse     <= coarseApplied;
         apertureDelay.fine       <= fine_q;
      end
   end

   // sysref captured on rising device clock edge
   always_ff @(posedge clk) begin
      if (rst) begin
         sysrefPrev_q <= 1'b0;
         sysrefSeen_q <= 1'b0;
      end else begin
         sysrefPrev_q <= sysrefIn;
         if (sysrefEdge) begin
            sysrefSeen_q <= 1'b1;
         end else if (ackNext && !wbReq.we && wbReq.adr == `ADDR_STATUS) begin
            sysrefSeen_q <= 1'b0;
         end
      end
   end

   // frame divider and strobe, reset by sysref
   always_ff @(posedge clk) begin
      if (rst) begin
         frameCnt_q       <= 8'h00;
         demuxCnt_q       <= 4'h0;
         laneClk_q        <= 1'b0;
         laneOutputStrobe <= 1'b0;
         laneOutputClock  <= 1'b0;
      end else if (sysrefEdge) begin
         frameCnt_q       <= 8'h00;
         demuxCnt_q       <= 4'h0;
         laneClk_q        <= 1'b0;
         laneOutputStrobe <= 1'b1;
         laneOutputClock  <= 1'b0;
      end else begin
         laneClk_q       <= ~laneClk_q;
         laneOutputClock <= laneClk_q;
         if (demuxCnt_q >= outputDemux_q) begin
            demuxCnt_q <= 4'h0;
            frameCnt_q <= (frameCnt_q + 8'h01 >= frameLength_q) ? 8'h00 : frameCnt_q + 8'h01;
            laneOutputStrobe <= (frameCnt_q + 8'h01 >= frameLength_q);
         end else begin
            demuxCnt_q       <= demuxCnt_q + 4'h1;
            laneOutputStrobe <= 1'b0;
         end
      end
   end

   // marker sampled alongside the data
   assign markerSrc = sysrefMarkerSelect_q ? sysrefIn : markerTriggerInput;

   // data pipeline with marker in the lsb
   always_ff @(posedge clk) begin
      if (rst) begin
         pipe_q <= '0;
      end else begin
         pipe_q[0][24]    <= sampleValid;
         pipe_q[0][23:13] <= sampleRise[11:1];
         pipe_q[0][12]    <= markerInsertEnable_q ? markerSrc : sampleRise[0];
         pipe_q[0][11:1]  <= sampleFall[11:1];
         // dual channel uses rising samples only
         pipe_q[0][0]     <= markerInsertEnable_q ? markerSrc : sampleFall[0];
         if (!singleChannel_q) begin
            pipe_q[0][11:0] <= 12'h000;
         end
         for (int i = 1; i < LATENCY; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         laneDataRise  <= 12'h000;
         laneDataFall  <= 12'h000;
         laneDataValid <= 1'b0;
      end else begin
         laneDataValid <= pipe_q[LATENCY-1][24];
         laneDataRise  <= pipe_q[LATENCY-1][23:12];
         laneDataFall  <= pipe_q[LATENCY-1][11:0];
      end
   end

endmodule : sample_clock_timestamp_sync
